// >>> eeprom_pkg.sv
// Types shared by the serial EEPROM command logic
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_READ,
    ST_WDATA,
    ST_STATUS,
    ST_LATCH,
    ST_IGNORE
  } state_t;

  typedef logic [7:0] byte_t;

endpackage : eeprom_pkg

// >>> eeprom_regs.svh
// Opcodes, status layout, array geometry and timing constants of the serial EEPROM
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define OP_READ           8'h03
`define OP_WRITE          8'h02
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLEAR    8'h04
`define OP_STATUS_READ    8'h05

`define ADDR_W            17
`define PAGE_W            8
`define PAGE_NUM_W        9
`define MEM_BYTES         131072
`define ADDR_BYTES        2'd2

`define ST_BUSY_BIT       0
`define ST_LATCH_BIT      1
`define ST_BP_LO_BIT      2
`define ST_BP_HI_BIT      3
`define ST_PROTECT_PIN_ENABLE_BIT_BIT       7
`define STATUS_NV_RESET   8'h00

`define REF_CLK_HZ        25000000
`define T_WRITE_MS        6
`define WRITE_CYCLES_DEF  (`T_WRITE_MS * `REF_CLK_HZ / 1000)

`endif

// >>> pin_sync.sv
// Two-flop synchronisers for the serial link pins
module pin_sync #(
  parameter int unsigned    WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // One process for all bits; meta may be metastable, so only sync_o leaves the module
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : pin_sync

// >>> spi_eeprom.sv
// Command logic of a 128 KiB serial EEPROM on an SPI-style link
//
// Contract
// RULE1: Read: opcode, 24-bit address, upper seven ignored.
// RULE2: After address, stored byte shifts out.
// RULE3: Pointer advances per byte; reading streams on.
// RULE4: Pointer wraps from top address to zero.
// RULE5: Chip select rise ends read; output released.
// RULE6: Latch sets only if select rises after opcode.
// RULE7: Each write has its own self-timed erase.
// RULE8: Write: opcode, address, 1..256 bytes, one page.
// RULE9: Unwritten bytes of the page are rewritten too.
// RULE10: Data past page end wraps within page.
// RULE11: Write starts only on rise after whole byte.
// RULE12: Array reads refused during internal write.
// RULE13: Write needs latch set; set/clear commands.
// RULE14: Latch cleared at power-up, disable, write end.
// RULE15: Status read works always, even while busy.
// RULE16: Status layout: protect enable, blocks, latch, busy.
// RULE17: Busy bit is one during internal write.
// RULE18: Latch bit mirrors latch; commands change it only as RULE6 allows.
// RULE19: Block-protect bits change only by status write.
// RULE20: Input sampled on rising clock, MSB first.
// RULE21: Read 03h and write 02h decoded first.
// RULE22: Latch set 06h, clear 04h, status 05h.
// RULE23: While busy, all but status read ignored.
`include "eeprom_regs.svh"

module spi_eeprom import eeprom_pkg::*; #(
  parameter int unsigned WRITE_CYCLES   = `WRITE_CYCLES_DEF,
  parameter logic [7:0]  STATUS_NV_INIT = `STATUS_NV_RESET
)(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_o
);

  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

  // Link pins, synchronised
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic cs_d;
  logic sck_d;

  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b100)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({cs_n_i, sck_i, si_i}),
    .sync_o    ({cs_s, sck_s, si_s})
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
    end
  end

  wire sck_rise = !cs_s && sck_s && !sck_d;
  wire sck_fall = !cs_s && !sck_s && sck_d;
  wire cs_rise  = cs_s && !cs_d;

  // Storage
  byte_t mem      [`MEM_BYTES];
  byte_t page_buf [1 << `PAGE_W];

  state_t                 state;
  logic [2:0]             bit_cnt;
  byte_t                  rx;
  logic [15:0]            addr_sr;
  logic [1:0]             addr_cnt;
  logic [`ADDR_W-1:0]     ptr;
  byte_t                  tx;
  logic [2:0]             out_cnt;
  logic                   latch_is_set;
  logic [`PAGE_NUM_W-1:0] page_sel;
  logic [`PAGE_W-1:0]     wr_idx;
  logic [255:0]           mask;
  logic                   latch_state_bit;
  logic                   busy;
  logic [TW-1:0]          timer;
  logic [8:0]             copy_idx;
  byte_t                  status_nv;

  wire byte_t next_rx   = {rx[6:0], si_s}; // RULE20
  wire        byte_end  = sck_rise && (bit_cnt == 3'd7);
  wire        op_end    = byte_end && (state == ST_OPCODE);
  wire        addr_end  = byte_end && (state == ST_ADDR) && (addr_cnt == `ADDR_BYTES);
  wire [`ADDR_W-1:0] addr_in = {addr_sr[`ADDR_W-9:0], next_rx}; // RULE1
  wire        wbyte     = byte_end && (state == ST_WDATA);
  wire        reload    = sck_fall && (state == ST_READ) && (out_cnt == 3'd7);
  wire        out_fall  = sck_fall && ((state == ST_READ) || (state == ST_STATUS));

  // Sector protection by the two block-protect bits
  function automatic logic page_protected(input logic [1:0] bp,
                                          input logic [`PAGE_NUM_W-1:0] pg);
    case (bp)
      2'b00:   page_protected = 1'b0;
      2'b01:   page_protected = (pg[8:7] == 2'b11);
      2'b10:   page_protected = pg[8];
      default: page_protected = 1'b1;
    endcase
  endfunction : page_protected

  // Bits 6..4 read as zero
  wire byte_t status_word = {status_nv[`ST_PROTECT_PIN_ENABLE_BIT_BIT], 3'b000,
                             status_nv[`ST_BP_HI_BIT], status_nv[`ST_BP_LO_BIT],
                             latch_state_bit, busy}; // RULE16 RULE17 RULE18

  wire [1:0] bp = {status_nv[`ST_BP_HI_BIT], status_nv[`ST_BP_LO_BIT]};

  wire commit = cs_rise && (state == ST_WDATA) && (bit_cnt == 3'd0) // RULE11
                && (|mask) && latch_state_bit && !busy // RULE8 RULE13
                && !page_protected(bp, page_sel); // RULE19

  // Command sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state        <= ST_OPCODE;
      bit_cnt      <= 3'd0;
      rx           <= 8'h00;
      addr_sr      <= 16'h0000;
      addr_cnt     <= 2'd0;
      ptr          <= '0;
      tx           <= 8'h00;
      out_cnt      <= 3'd0;
      latch_is_set <= 1'b0;
      page_sel     <= '0;
      wr_idx       <= '0;
      mask         <= '0;
      so_o         <= 1'b0;
      so_oe_o      <= 1'b0;
    end else if (cs_s) begin
      state   <= ST_OPCODE;
      bit_cnt <= 3'd0;
      out_cnt <= 3'd0;
      so_o    <= 1'b0;
      so_oe_o <= 1'b0; // RULE5
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'd1;
      rx      <= next_rx;
      case (state)
        ST_OPCODE: begin
          if (byte_end) begin
            if (busy && (next_rx != `OP_STATUS_READ)) begin
              state <= ST_IGNORE; // RULE12 RULE23
            end else begin
              case (next_rx) // RULE21 RULE22
                `OP_READ, `OP_WRITE: begin
                  state    <= ST_ADDR;
                  addr_cnt <= 2'd0;
                  latch_is_set <= (next_rx == `OP_WRITE);
                end
                `OP_STATUS_READ: begin
                  state   <= ST_STATUS; // RULE15
                  tx      <= status_word;
                  out_cnt <= 3'd0;
                end
                `OP_LATCH_SET: begin
                  state        <= ST_LATCH;
                  latch_is_set <= 1'b1;
                end
                `OP_LATCH_CLEAR: begin
                  state        <= ST_LATCH;
                  latch_is_set <= 1'b0;
                end
                default: state <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (byte_end) begin
            addr_sr  <= {addr_sr[7:0], next_rx};
            addr_cnt <= addr_cnt + 2'd1;
          end
          if (addr_end && !latch_is_set) begin
            state   <= ST_READ;
            tx      <= mem[addr_in]; // RULE2
            ptr     <= addr_in + `ADDR_W'(1);
            out_cnt <= 3'd0;
          end else if (addr_end) begin
            state    <= ST_WDATA;
            page_sel <= addr_in[`ADDR_W-1:`PAGE_W];
            wr_idx   <= addr_in[`PAGE_W-1:0];
            mask     <= '0;
          end
        end
        ST_WDATA: begin
          if (wbyte) begin
            mask[wr_idx] <= 1'b1;
            wr_idx       <= wr_idx + `PAGE_W'(1); // RULE10
          end
        end
        // A ninth clock after a latch opcode voids the command
        ST_LATCH: state <= ST_IGNORE; // RULE6
        ST_READ, ST_STATUS, ST_IGNORE: state <= state;
        default: state <= ST_IGNORE;
      endcase
    end else if (out_fall) begin
      so_o    <= tx[7]; // RULE20
      so_oe_o <= 1'b1;
      tx      <= {tx[6:0], 1'b0};
      out_cnt <= out_cnt + 3'd1;
      if (reload) begin
        tx  <= mem[ptr]; // RULE3
        ptr <= ptr + `ADDR_W'(1); // RULE4
      end else if (out_cnt == 3'd7) begin
        tx <= status_word;
      end
    end
  end

  // Latch, busy timer and page copy
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      latch_state_bit       <= 1'b0; // RULE14
      busy      <= 1'b0;
      timer     <= '0;
      copy_idx  <= 9'd0;
      status_nv <= STATUS_NV_INIT; // RULE19
    end else begin
      if (cs_rise && (state == ST_LATCH)) begin
        latch_state_bit <= latch_is_set; // RULE6 RULE13 RULE14 RULE18
      end
      if (commit) begin
        busy     <= 1'b1; // RULE7
        timer    <= TW'(WRITE_CYCLES - 1);
        copy_idx <= 9'd0;
      end else if (busy) begin
        if (!copy_idx[8]) begin
          copy_idx <= copy_idx + 9'd1;
        end
        if (timer == '0) begin
          busy <= 1'b0;
          latch_state_bit  <= 1'b0; // RULE14
        end else begin
          timer <= timer - TW'(1);
        end
      end
    end
  end

  // Whole page goes through the cycle; untouched bytes are refreshed
  wire [`ADDR_W-1:0] copy_addr = {page_sel, copy_idx[7:0]};

  always_ff @(posedge ref_clk_i) begin
    if (busy && !copy_idx[8]) begin
      mem[copy_addr] <= mask[copy_idx[7:0]] ? page_buf[copy_idx[7:0]] : mem[copy_addr]; // RULE9
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!cs_s && wbyte) begin
      page_buf[wr_idx] <= next_rx; // RULE8
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_commit;
    commit;
  endsequence

  sequence s_busy_run;
    busy [*8];
  endsequence

  sequence s_bad_stop;
    cs_rise && (state == ST_WDATA) && (bit_cnt != 3'd0) && !busy;
  endsequence

  busy_start_a: assert property (s_commit |=> s_busy_run) // RULE7
    else $error("internal write did not hold busy");
  write_end_a: assert property (busy && (timer == '0) |=> !busy && !latch_state_bit) // RULE14
    else $error("latch not cleared at end of write");
  oe_release_a: assert property (cs_rise |=> !so_oe_o) // RULE5
    else $error("output still driven after select rise");
  busy_ignore_a: assert property (op_end && busy && (next_rx != `OP_STATUS_READ)
                                  |=> state == ST_IGNORE) // RULE23
    else $error("command taken while busy");
  addr_wrap_a: assert property (reload && (ptr == '1) |=> ptr == '0) // RULE4
    else $error("read pointer did not wrap");
  ptr_step_a: assert property (reload |=> ptr == $past(ptr) + `ADDR_W'(1)) // RULE3
    else $error("read pointer did not advance");
  latch_set_a: assert property (cs_rise && (state == ST_LATCH) && latch_is_set
                                |=> latch_state_bit) // RULE6
    else $error("latch not set after enable");
  page_wrap_a: assert property (wbyte && (wr_idx == '1) |=> wr_idx == '0) // RULE10
    else $error("page index did not wrap");
  status_load_a: assert property (out_fall && (state == ST_STATUS) && (out_cnt == 3'd7)
                                  |=> tx == $past(status_word)) // RULE16
    else $error("status byte not reloaded");
  partial_abort_a: assert property (s_bad_stop |=> !busy) // RULE11
    else $error("write started off a byte boundary");
  protect_drop_a: assert property (cs_rise && (state == ST_WDATA) && !busy // RULE19
                                   && page_protected(bp, page_sel) |=> !busy)
    else $error("write started in a protected block");

endmodule : spi_eeprom

// >>> spi_host_model.sv
// Behavioural SPI controller that frames commands towards the EEPROM
module spi_host_model (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 160ns;
  logic line;

  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
    line   = 1'b0;
  end

  // Mode 0: data set while sck is low, taken on the rise; sck idles low between frames
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx,
                       output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    cs_n_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o <= tx[63-i];
      #(HALF);
      sck_o <= 1'b1;
      // A released output shows no stale level: the line flips instead
      line = so_oe_i ? so_i : ~line;
      rx[63-i] = line;
      oe_seen |= so_oe_i;
      #(HALF);
      sck_o <= 1'b0;
    end
    #(HALF);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o;
    #(3*HALF);
  endtask : frame
endmodule : spi_host_model

// >>> tb_top.sv
// Self-checking bench for the serial EEPROM command logic
`include "eeprom_regs.svh"
module tb_top import eeprom_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    byte_t       op;
    logic [23:0] adr;
    logic [31:0] dat;
    int          nb;
    logic        chk;
    logic [15:0] exp;
  } row_t;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so_o;
  logic        so_oe_o;
  logic        cs_n_prot;
  logic        sck_prot;
  logic        si_prot;
  logic        so_prot;
  logic        so_oe_prot;
  logic [63:0] rx;
  logic        oe;
  int          failures  = 0;
  int          tests_run = 0;
  row_t rows [28] = '{
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0000},
    '{8'h06, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0202},
    '{8'h04, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0000},
    '{8'h06, 24'h0, 32'h0, 9, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0000},
    '{8'h06, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h02, 24'hfe01fe, 32'ha0a1a2a3, 64, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0000},
    '{8'h03, 24'h0001fe, 32'h0, 48, 1, 16'ha0a1},
    '{8'h03, 24'h000100, 32'h0, 48, 1, 16'ha2a3},
    '{8'h06, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h02, 24'h01fffe, 32'h695a0000, 48, 0, 16'h0},
    '{8'h06, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h02, 24'h000000, 32'hc3000000, 40, 0, 16'h0},
    '{8'h03, 24'h01ffff, 32'h0, 48, 1, 16'h5ac3},
    '{8'h03, 24'h01fffe, 32'h0, 48, 1, 16'h695a},
    '{8'h02, 24'h01ffff, 32'h11000000, 40, 0, 16'h0},
    '{8'h03, 24'h01ffff, 32'h0, 48, 1, 16'h5ac3},
    '{8'h06, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h02, 24'h01ffff, 32'h22200000, 44, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0202},
    '{8'h03, 24'h01ffff, 32'h0, 48, 1, 16'h5ac3},
    '{8'h04, 24'h0, 32'h0, 8, 0, 16'h0},
    '{8'h06, 24'h0201ff, 32'hff770000, 48, 0, 16'h0},
    '{8'h05, 24'h0, 32'h0, 24, 1, 16'h0000},
    '{8'h03, 24'h01ffff, 32'h0, 48, 1, 16'h5ac3}
  };

  always #20 ref_clk = ~ref_clk;

  spi_eeprom #(.WRITE_CYCLES(300)) i_dut (
    .ref_clk_i (ref_clk),
    .rstn_i    (rstn),
    .cs_n_i    (cs_n),
    .sck_i     (sck),
    .si_i      (si),
    .so_o      (so_o),
    .so_oe_o   (so_oe_o)
  );

  spi_host_model i_host (
    .cs_n_o  (cs_n),
    .sck_o   (sck),
    .si_o    (si),
    .so_i    (so_o),
    .so_oe_i (so_oe_o)
  );

  // Second device powers up with protect enable and both block-protect bits set
  spi_eeprom #(.WRITE_CYCLES(300), .STATUS_NV_INIT(8'h8c)) i_dut_prot (
    .ref_clk_i (ref_clk),
    .rstn_i    (rstn),
    .cs_n_i    (cs_n_prot),
    .sck_i     (sck_prot),
    .si_i      (si_prot),
    .so_o      (so_prot),
    .so_oe_o   (so_oe_prot)
  );

  spi_host_model i_host_prot (
    .cs_n_o  (cs_n_prot),
    .sck_o   (sck_prot),
    .si_o    (si_prot),
    .so_i    (so_prot),
    .so_oe_i (so_oe_prot)
  );

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // Polls the busy bit a bounded number of times
  task automatic wait_idle();
    for (int n = 0; n < 20; n++) begin
      i_host.frame({`OP_STATUS_READ, 56'h0}, 16, rx, oe);
      if (rx[48] === 1'b0)
        return;
    end
    failures++;
    $display("mismatch busy_wait expected 0 seen 1");
    results();
  endtask : wait_idle

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int r = 0; r < 28; r++) begin
      i_host.frame({rows[r].op, rows[r].adr, rows[r].dat}, rows[r].nb, rx, oe);
      if (rows[r].op == `OP_WRITE)
        wait_idle();
      if (rows[r].chk)
        check("row", rows[r].exp,
              (rows[r].op == `OP_READ) ? rx[31:16] : rx[55:40]);
      check("so_release", 16'h0, {15'h0, so_oe_o});
    end
    // Busy window: status stays readable while an array read is turned away
    i_host.frame({`OP_LATCH_SET, 56'h0}, 8, rx, oe);
    i_host.frame({`OP_WRITE, 24'h000010, 8'h55, 24'h0}, 40, rx, oe);
    i_host.frame({`OP_STATUS_READ, 56'h0}, 16, rx, oe);
    check("busy_status", 16'h0003, {8'h00, rx[55:48]});
    i_host.frame({`OP_READ, 24'h000010, 32'h0}, 48, rx, oe);
    check("busy_read_oe", 16'h0, {15'h0, oe});
    wait_idle();
    i_host.frame({`OP_READ, 24'h000010, 32'h0}, 40, rx, oe);
    check("after_busy", 16'h0055, {8'h00, rx[31:24]});
    // Fully protected array: the write is dropped, the latch still obeys its commands
    i_host_prot.frame({`OP_LATCH_SET, 56'h0}, 8, rx, oe);
    i_host_prot.frame({`OP_WRITE, 24'h000010, 8'h55, 24'h0}, 40, rx, oe);
    i_host_prot.frame({`OP_STATUS_READ, 56'h0}, 16, rx, oe);
    check("prot_status", 16'h008e, {8'h00, rx[55:48]});
    i_host_prot.frame({`OP_LATCH_CLEAR, 56'h0}, 8, rx, oe);
    i_host_prot.frame({`OP_STATUS_READ, 56'h0}, 16, rx, oe);
    check("prot_clear", 16'h008c, {8'h00, rx[55:48]});
    // Latch must come back cleared after a reset in mid-run
    i_host.frame({`OP_LATCH_SET, 56'h0}, 8, rx, oe);
    rstn <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    i_host.frame({`OP_STATUS_READ, 56'h0}, 16, rx, oe);
    check("reset_status", 16'h0000, {8'h00, rx[55:48]});
    results();
  end
endmodule : tb_top
